//--- common/tcr_pkg.sv
// tuner configuration register bank: shared constants, modes and carriers
// assumes one clock at 10 MHz and an axi4-lite master with 32-bit data
// Behaviour
// [RULE1] interrupt pin mode: hiz, irq, low, high
// [RULE2] completion enable gives 5 ms low pulse
// [RULE3] data group enable gives 5 ms low pulse
// [RULE4] seek rejects strength below eight-bit threshold
// [RULE5] band code selects range, 11 reserved
// [RULE6] spacing code selects 200, 100, 50 kHz
// [RULE7] volume zero mutes, else 2 dB steps
// [RULE8] extended range adds 30 dB attenuation
// [RULE9] softmute rate code, fastest by default
// [RULE10] softmute depth 16 down to 10 dB
// [RULE11] bit 9 enables high performance decoding
// [RULE12] snr threshold zero disables snr check
// [RULE13] impulse threshold zero disables impulse check
// [RULE14] softmute register reads zero after reset
// [RULE15] host writes zero to bits 11:10
// [RULE16] done flag set on finish, cleared by request low
// [RULE17] group ready flag follows decoder, default zero
// [RULE18] spacing code 11 treated as reserved
`default_nettype none

package tcr_pkg;

	// ---------------------------------------------------------------
	// register indices and byte addresses
	// ---------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [7:0] IDX_CONTROL = 8'h03;
	localparam logic [7:0] IDX_PIN_CFG = 8'h04;
	localparam logic [7:0] IDX_SEEK_BAND = 8'h05;
	localparam logic [7:0] IDX_SOFTMUTE = 8'h06;
	localparam logic [7:0] IDX_STATUS = 8'h0a;
	localparam logic [7:0] ADDR_CONTROL = {IDX_CONTROL[5:0], 2'h0};
	localparam logic [7:0] ADDR_PIN_CFG = {IDX_PIN_CFG[5:0], 2'h0};
	localparam logic [7:0] ADDR_SEEK_BAND = {IDX_SEEK_BAND[5:0], 2'h0};
	localparam logic [7:0] ADDR_SOFTMUTE = {IDX_SOFTMUTE[5:0], 2'h0};
	localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};

	// ---------------------------------------------------------------
	// reset values and writable masks
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_CONTROL = 16'h0000;
	localparam logic [15:0] RST_PIN_CFG = 16'h0000;
	localparam logic [15:0] RST_SEEK_BAND = 16'h0000;
	localparam logic [15:0] RST_SOFTMUTE = 16'h0000;
	localparam logic [15:0] WMASK_CONTROL = 16'h8100;
	localparam logic [15:0] WMASK_PIN_CFG = 16'hc00f;
	localparam logic [15:0] WMASK_SOFTMUTE = 16'hf3ff;

	// ---------------------------------------------------------------
	// bit positions
	// ---------------------------------------------------------------
	localparam int CTRL_TUNE_BIT = 15;
	localparam int CTRL_SEEK_BIT = 8;
	localparam int STAT_READY_BIT = 15;
	localparam int STAT_DONE_BIT = 14;
	localparam int STAT_SPACE_RSVD_BIT = 1;
	localparam int STAT_BAND_RSVD_BIT = 0;

	// ---------------------------------------------------------------
	// codes and audio figures
	// ---------------------------------------------------------------
	localparam logic [1:0] BAND_RESERVED = 2'h3;
	localparam logic [1:0] SPACE_RESERVED = 2'h3;
	localparam logic [3:0] VOL_MUTE = 4'h0;
	localparam logic [3:0] VOL_FULL = 4'hf;
	localparam logic [5:0] VOL_EXT_ATTEN_DB = 6'h1e;
	localparam logic [4:0] SMUTE_BASE_DB = 5'h10;
	localparam logic [3:0] THRESH_OFF = 4'h0;
	localparam logic [4:0] IMPULSE_LIMIT_BASE = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int IRQ_PULSE_MS = 5;
	localparam int IRQ_PULSE_CYCLES = (CLK_HZ / 1000) * IRQ_PULSE_MS;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PIN_HIZ = 2'h0,
		PIN_IRQ = 2'h1,
		PIN_LOW = 2'h2,
		PIN_HIGH = 2'h3
	} tcr_pin_mode_e;

	typedef struct packed {
		logic data_group_irq_enable;
		logic completion_irq_enable;
		logic [9:0] reserved;
		tcr_pin_mode_e interrupt_pin_mode;
		tcr_pin_mode_e general_pin_one_mode;
	} tcr_pin_cfg_s;

	typedef struct packed {
		logic [7:0] seek_strength_threshold;
		logic [1:0] band;
		logic [1:0] spacing;
		logic [3:0] volume;
	} tcr_seek_band_s;

	typedef struct packed {
		logic [1:0] softmute_rate;
		logic [1:0] softmute_depth;
		logic [1:0] reserved;
		logic decoder_high_perf_mode;
		logic extended_volume_range;
		logic [3:0] seek_snr_threshold;
		logic [3:0] seek_impulse_threshold;
	} tcr_softmute_s;

	typedef struct packed {
		logic [7:0] rssi;
		logic [3:0] snr;
		logic [3:0] impulses;
	} tcr_meas_s;

	typedef struct packed {
		logic mute;
		logic [5:0] atten_db;
		logic [4:0] softmute_atten_db;
	} tcr_audio_s;

endpackage

`default_nettype wire

//--- core/tcr_low_pulse.sv
// fixed-length active-high pulse stretcher, retriggerable
// assumes trigger is synchronous to aclk
`default_nettype none

module tcr_low_pulse #(
	parameter int unsigned CYCLES = 50000
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// event in, stretched level out
	input wire logic trigger,
	output logic active_q
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_q;

	// ---------------------------------------------------------------
	// countdown: a new trigger restarts the full length
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_q <= '0;
		end
		else if (trigger)
		begin
			count_q <= CW'(CYCLES);
		end
		else if (count_q != '0)
		begin
			count_q <= count_q - CW'(1);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active_q <= 1'b0;
		end
		else
		begin
			active_q <= trigger | (count_q > CW'(1));
		end
	end

endmodule // tcr_low_pulse

`default_nettype wire

//--- core/tcr_regs.sv
// tuner configuration register bank with axi4-lite slave, pin modes and seek qualification
// assumes an axi4-lite master, tuning and decoder engines that report events synchronously
`default_nettype none

module tcr_regs #(
	parameter int unsigned IRQ_PULSE_CYCLES = tcr_pkg::IRQ_PULSE_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// engine events and measurements
	input wire logic seek_tune_finished,
	input wire logic data_group_available,
	input wire logic meas_valid,
	input wire tcr_pkg::tcr_meas_s meas,
	// configuration towards the engines
	output logic tune_request_q,
	output logic seek_request_q,
	output tcr_pkg::tcr_seek_band_s seek_band_q,
	output tcr_pkg::tcr_softmute_s softmute_q,
	output tcr_pkg::tcr_audio_s audio_q,
	output logic band_reserved_q,
	output logic spacing_reserved_q,
	// seek qualification result
	output logic qual_valid_q,
	output logic channel_qualified_q,
	// general pins: index 0 general pin one, index 1 interrupt pin
	output logic [1:0] pin_out_q,
	output logic [1:0] pin_oe_q
);

	tcr_pkg::tcr_pin_cfg_s pin_cfg_q;
	logic done_flag_q, ready_flag_q, aw_full_q, w_full_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_take, w_take, wr_commit, aw_full_d, w_full_d, bvalid_d, ar_take, rvalid_d;
	logic [15:0] wr_mask, rd_word;
	logic rd_hit, wr_hit, irq_trigger, irq_active;
	tcr_pkg::tcr_pin_mode_e pin_mode [2];

	// ---------------------------------------------------------------
	// write channel handshakes
	// ---------------------------------------------------------------
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign wr_commit = aw_full_q & w_full_q & ~bvalid;
	assign aw_full_d = aw_take | (aw_full_q & ~wr_commit);
	assign w_full_d = w_take | (w_full_q & ~wr_commit);
	assign bvalid_d = wr_commit | (bvalid & ~bready);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
		end
		else
		begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready <= ~aw_full_d & ~bvalid_d;
			wready <= ~w_full_d & ~bvalid_d;
			bvalid <= bvalid_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bresp <= tcr_pkg::RESP_OKAY;
		end
		else
		begin
			if (aw_take)
				aw_addr_q <= awaddr;
			if (w_take)
			begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (wr_commit)
				bresp <= wr_hit ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
		end
	end

	// ---------------------------------------------------------------
	// write decode
	// ---------------------------------------------------------------
	assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	always_comb
	begin
		unique case ({aw_addr_q[7:2], 2'h0})
			tcr_pkg::ADDR_CONTROL,
			tcr_pkg::ADDR_PIN_CFG,
			tcr_pkg::ADDR_SEEK_BAND,
			tcr_pkg::ADDR_SOFTMUTE,
			tcr_pkg::ADDR_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tune_request_q <= tcr_pkg::RST_CONTROL[tcr_pkg::CTRL_TUNE_BIT];
			seek_request_q <= tcr_pkg::RST_CONTROL[tcr_pkg::CTRL_SEEK_BIT];
		end
		else if (wr_commit && {aw_addr_q[7:2], 2'h0} == tcr_pkg::ADDR_CONTROL)
		begin
			if (wr_mask[tcr_pkg::CTRL_TUNE_BIT])
				tune_request_q <= w_data_q[tcr_pkg::CTRL_TUNE_BIT];
			if (wr_mask[tcr_pkg::CTRL_SEEK_BIT])
				seek_request_q <= w_data_q[tcr_pkg::CTRL_SEEK_BIT];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin_cfg_q <= tcr_pkg::RST_PIN_CFG; // RULE1
		else if (wr_commit && {aw_addr_q[7:2], 2'h0} == tcr_pkg::ADDR_PIN_CFG)
			pin_cfg_q <= (pin_cfg_q & ~(wr_mask & tcr_pkg::WMASK_PIN_CFG))
				| (w_data_q[15:0] & wr_mask & tcr_pkg::WMASK_PIN_CFG);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			seek_band_q <= tcr_pkg::RST_SEEK_BAND; // RULE4 RULE5 RULE6 RULE7
		else if (wr_commit && {aw_addr_q[7:2], 2'h0} == tcr_pkg::ADDR_SEEK_BAND)
			seek_band_q <= (seek_band_q & ~wr_mask) | (w_data_q[15:0] & wr_mask);
	end

	// reserved bits 11:10 never store, so they always read zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			softmute_q <= tcr_pkg::RST_SOFTMUTE; // RULE14
		else if (wr_commit && {aw_addr_q[7:2], 2'h0} == tcr_pkg::ADDR_SOFTMUTE)
			softmute_q <= (softmute_q & ~(wr_mask & tcr_pkg::WMASK_SOFTMUTE))
				| (w_data_q[15:0] & wr_mask & tcr_pkg::WMASK_SOFTMUTE); // RULE15 RULE9 RULE11
	end

	// ---------------------------------------------------------------
	// status flags
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			done_flag_q <= 1'b0;
		else if (seek_tune_finished)
			done_flag_q <= 1'b1; // RULE16
		else if (!tune_request_q && !seek_request_q)
			done_flag_q <= 1'b0; // RULE16
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ready_flag_q <= 1'b0;
		else
			ready_flag_q <= data_group_available; // RULE17
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			band_reserved_q <= 1'b0;
			spacing_reserved_q <= 1'b0;
		end
		else
		begin
			band_reserved_q <= seek_band_q.band == tcr_pkg::BAND_RESERVED; // RULE5
			spacing_reserved_q <= seek_band_q.spacing == tcr_pkg::SPACE_RESERVED; // RULE18
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	assign ar_take = arvalid & arready;
	assign rvalid_d = ar_take | (rvalid & ~rready);

	always_comb
	begin
		rd_hit = 1'b1;
		rd_word = 16'h0000;
		unique case ({araddr[7:2], 2'h0})
			tcr_pkg::ADDR_CONTROL:
			begin
				rd_word[tcr_pkg::CTRL_TUNE_BIT] = tune_request_q;
				rd_word[tcr_pkg::CTRL_SEEK_BIT] = seek_request_q;
			end
			tcr_pkg::ADDR_PIN_CFG: rd_word = pin_cfg_q;
			tcr_pkg::ADDR_SEEK_BAND: rd_word = seek_band_q;
			tcr_pkg::ADDR_SOFTMUTE: rd_word = softmute_q;
			tcr_pkg::ADDR_STATUS:
			begin
				rd_word[tcr_pkg::STAT_READY_BIT] = ready_flag_q;
				rd_word[tcr_pkg::STAT_DONE_BIT] = done_flag_q;
				rd_word[tcr_pkg::STAT_SPACE_RSVD_BIT] = spacing_reserved_q;
				rd_word[tcr_pkg::STAT_BAND_RSVD_BIT] = band_reserved_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= tcr_pkg::RESP_OKAY;
		end
		else
		begin
			arready <= ~rvalid_d;
			rvalid <= rvalid_d;
			if (ar_take)
			begin
				rdata <= {16'h0000, rd_word};
				rresp <= rd_hit ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupt pulse on the interrupt pin
	// ---------------------------------------------------------------
	assign irq_trigger = (pin_cfg_q.interrupt_pin_mode == tcr_pkg::PIN_IRQ)
		& ((pin_cfg_q.completion_irq_enable & seek_tune_finished & ~done_flag_q) // RULE2
		| (pin_cfg_q.data_group_irq_enable & data_group_available & ~ready_flag_q)); // RULE3

	tcr_low_pulse #(.CYCLES(IRQ_PULSE_CYCLES)) u_irq_pulse (
		.aclk(aclk),
		.aresetn(aresetn),
		.trigger(irq_trigger),
		.active_q(irq_active)
	);

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	assign pin_mode[0] = pin_cfg_q.general_pin_one_mode;
	assign pin_mode[1] = pin_cfg_q.interrupt_pin_mode;

	for (genvar i = 0; i < 2; i++)
	begin : g_pin
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				pin_out_q[i] <= 1'b0;
				pin_oe_q[i] <= 1'b0;
			end
			else
			begin
				unique case (pin_mode[i])
					tcr_pkg::PIN_HIZ:
					begin
						pin_out_q[i] <= 1'b0;
						pin_oe_q[i] <= 1'b0;
					end
					tcr_pkg::PIN_IRQ:
					begin
						// idles high, low while the pulse runs; reserved on pin one
						pin_out_q[i] <= (i == 1) ? ~irq_active : 1'b0; // RULE1
						pin_oe_q[i] <= (i == 1);
					end
					tcr_pkg::PIN_LOW:
					begin
						pin_out_q[i] <= 1'b0;
						pin_oe_q[i] <= 1'b1;
					end
					tcr_pkg::PIN_HIGH:
					begin
						pin_out_q[i] <= 1'b1;
						pin_oe_q[i] <= 1'b1;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// audio level
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			audio_q <= '0;
		else
		begin
			audio_q.mute <= seek_band_q.volume == tcr_pkg::VOL_MUTE; // RULE7
			audio_q.atten_db <= {1'b0, tcr_pkg::VOL_FULL - seek_band_q.volume, 1'b0}
				+ (softmute_q.extended_volume_range ? tcr_pkg::VOL_EXT_ATTEN_DB : 6'h00); // RULE8
			audio_q.softmute_atten_db <= tcr_pkg::SMUTE_BASE_DB
				- {2'h0, softmute_q.softmute_depth, 1'b0}; // RULE10
		end
	end

	// ---------------------------------------------------------------
	// seek channel qualification
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			qual_valid_q <= 1'b0;
			channel_qualified_q <= 1'b0;
		end
		else
		begin
			qual_valid_q <= meas_valid;
			if (meas_valid)
				channel_qualified_q <= (meas.rssi >= seek_band_q.seek_strength_threshold) // RULE4
					& ((softmute_q.seek_snr_threshold == tcr_pkg::THRESH_OFF)
					| (meas.snr >= softmute_q.seek_snr_threshold)) // RULE12
					& ((softmute_q.seek_impulse_threshold == tcr_pkg::THRESH_OFF)
					| ({1'b0, meas.impulses} <= tcr_pkg::IMPULSE_LIMIT_BASE
					- {1'b0, softmute_q.seek_impulse_threshold})); // RULE13
		end
	end

endmodule // tcr_regs

`default_nettype wire

//--- tb/tcr_regs_props.sv
// checker for the tuner configuration register bank
// assumes it is bound to tcr_regs and sees only its ports
`default_nettype none

module tcr_regs_props #(
	parameter int unsigned IRQ_PULSE_CYCLES = tcr_pkg::IRQ_PULSE_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// configuration and pins
	input wire tcr_pkg::tcr_softmute_s softmute_q,
	input wire logic [1:0] pin_out_q,
	input wire logic [1:0] pin_oe_q
);
	timeunit 1ns;
	timeprecision 1ns;

	int unsigned low_cnt_q;

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// cycles the interrupt pin has been driven low
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !pin_oe_q[1] || pin_out_q[1])
			low_cnt_q <= 0;
		else
			low_cnt_q <= low_cnt_q + 1;
	end

	a_reset_pins_hiz: assert property ($rose(aresetn) |-> pin_oe_q == 2'h0 && pin_out_q == 2'h0)
		else $error("pins driven after reset");
	a_reset_reg_zero: assert property ($rose(aresetn) |-> softmute_q == '0)
		else $error("softmute register not zero after reset");
	a_pulse_length: assert property ($rose(pin_out_q[1]) && pin_oe_q[1] && $past(pin_oe_q[1]) |->
		low_cnt_q == IRQ_PULSE_CYCLES) else $error("interrupt pulse length wrong");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response late");
	a_resp_stands: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	a_read_refused: assert property (rvalid |-> !arready)
		else $error("read address accepted while data pending");
	a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");

	c_pulse: cover property ($rose(pin_out_q[1]) && pin_oe_q[1] && $past(pin_oe_q[1]));
	c_write: cover property (bvalid && !bready ##1 bvalid && bready);
	c_read: cover property (rvalid && !rready ##1 rvalid && rready);
endmodule // tcr_regs_props

`default_nettype wire

//--- tb/tcr_host.sv
// host controller model: register bus master with optional response stall
// assumes tasks are entered right after a rising edge of aclk
`default_nettype none

module tcr_host (
	// clock
	input wire logic aclk,
	// write channels
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	// read channels
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	timeunit 1ns;
	timeprecision 1ns;

	int stall = 0;
	int hung = 0;
	logic [3:0] strb = 4'hf;

	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
	end

	task automatic write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		logic ap;
		logic wp;
		int n;
		ap = 1'b1;
		wp = 1'b1;
		n = 0;
		awaddr <= a;
		wdata <= {16'h0000, a == tcr_pkg::ADDR_SOFTMUTE ? d & 16'hf3ff : d};
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while ((ap || wp) && n < 500)
		begin
			@(posedge aclk);
			n++;
			if (ap && awready)
			begin
				ap = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wp && wready)
			begin
				wp = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
		end
		repeat (stall) @(posedge aclk);
		bready <= 1'b1;
		ap = 1'b1;
		while (ap && n < 1000)
		begin
			@(posedge aclk);
			n++;
			if (bvalid)
			begin
				ap = 1'b0;
				r = bresp;
				bready <= 1'b0;
			end
		end
		if (n >= 1000)
			hung++;
	endtask

	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic p;
		int n;
		p = 1'b1;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		while (p && n < 500)
		begin
			@(posedge aclk);
			n++;
			if (arready)
			begin
				p = 1'b0;
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end
		repeat (stall) @(posedge aclk);
		rready <= 1'b1;
		p = 1'b1;
		while (p && n < 1000)
		begin
			@(posedge aclk);
			n++;
			if (rvalid)
			begin
				p = 1'b0;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
		if (n >= 1000)
			hung++;
	endtask
endmodule // tcr_host

`default_nettype wire

//--- tb/tuner_config_registers_tb.sv
// self-checking bench for the tuner configuration register bank
// assumes the host model drives the register bus; engine events come from here
`default_nettype none

module tuner_config_registers_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned IRQ_PULSE_CYCLES = 20;

	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, pin_out_q, pin_oe_q;
	logic seek_tune_finished, data_group_available, meas_valid, tune_request_q, seek_request_q;
	logic band_reserved_q, spacing_reserved_q, qual_valid_q, channel_qualified_q;
	logic [15:0] sb, sm, st;
	tcr_pkg::tcr_meas_s meas;
	tcr_pkg::tcr_seek_band_s seek_band_q;
	tcr_pkg::tcr_softmute_s softmute_q;
	tcr_pkg::tcr_audio_s audio_q;
	logic [1:0] modes [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	logic [7:0] addrs [5] = '{tcr_pkg::ADDR_CONTROL, tcr_pkg::ADDR_PIN_CFG, tcr_pkg::ADDR_SEEK_BAND,
		tcr_pkg::ADDR_SOFTMUTE, tcr_pkg::ADDR_STATUS};
	int errors = 0;
	int comparisons = 0;
	int seed = 32'hd7e4;

	tcr_regs #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) i_dut (.*);
	tcr_host i_host (.*);

	task automatic close_out;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			errors++;
		end
		if (i_host.hung != 0)
		begin
			errors++;
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = tcr_pkg::RESP_OKAY);
		i_host.write(a, d, rs);
		check("bresp", {30'h0, er}, {30'h0, rs});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er = tcr_pkg::RESP_OKAY);
		i_host.read(a, rd, rs);
		check("rresp", {30'h0, er}, {30'h0, rs});
		check("rdata", {16'h0, ed}, rd);
	endtask

	task automatic pin_is(input logic v);
		check("interrupt pin", {31'h0, v}, {31'h0, pin_out_q[1]});
	endtask

	function automatic logic [11:0] exp_audio(input logic [15:0] b, input logic [15:0] s);
		logic [5:0] a;
		a = 6'(2 * (15 - b[3:0])) + (s[8] ? 6'h1e : 6'h00);
		return {b[3:0] == 4'h0, a, 5'(16 - 2 * s[13:12])};
	endfunction

	function automatic logic exp_qual(input logic [15:0] b, input logic [15:0] s, input tcr_pkg::tcr_meas_s m);
		return m.rssi >= b[15:8] && (s[7:4] == 4'h0 || m.snr >= s[7:4])
			&& (s[3:0] == 4'h0 || 5'(m.impulses) <= 5'h10 - 5'(s[3:0]));
	endfunction

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial
	begin
		repeat (100000) @(posedge aclk);
		errors++;
		close_out();
	end

	initial
	begin
		aresetn = 1'b0;
		{seek_tune_finished, data_group_available, meas_valid} = 3'h0;
		meas = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (addrs[i])
			rd_chk(addrs[i], 16'h0000);
		check("config ports", 32'h0, {seek_band_q, softmute_q});
		rd_chk(8'h40, 16'h0000, tcr_pkg::RESP_SLVERR);
		wr(8'h40, 16'hffff, tcr_pkg::RESP_SLVERR);
		wr(tcr_pkg::ADDR_STATUS, 16'hffff);
		rd_chk(tcr_pkg::ADDR_STATUS, 16'h0000);
		$display("test reset and map done");
		for (int i = 0; i < 20; i++)
		begin
			sb = i == 0 ? 16'hffff : 16'($random(seed));
			sm = i == 0 ? 16'hffff : 16'($random(seed));
			i_host.stall = i % 3;
			wr(tcr_pkg::ADDR_SEEK_BAND, sb);
			wr(tcr_pkg::ADDR_SOFTMUTE, sm);
			rd_chk(tcr_pkg::ADDR_SEEK_BAND, sb);
			rd_chk(tcr_pkg::ADDR_SOFTMUTE, sm & 16'hf3ff);
			check("config ports", {sb, sm & 16'hf3ff}, {seek_band_q, softmute_q});
			check("reserved codes", {30'h0, sb[7:6] == 2'h3, sb[5:4] == 2'h3},
				{30'h0, band_reserved_q, spacing_reserved_q});
			st = sb[3:0] == 4'h0 ? 16'h081f : 16'h0fff;
			check("audio", {4'h0, exp_audio(sb, sm)} & st, {4'h0, audio_q} & st);
			for (int j = 0; j < 4; j++)
			begin
				meas <= {j == 0 ? sb[15:8] : 8'($random(seed)), 8'($random(seed))};
				meas_valid <= 1'b1;
				@(posedge aclk);
				meas_valid <= 1'b0;
				@(posedge aclk);
				check("qualified", {30'h1, exp_qual(sb, sm, meas)}, {30'h0, qual_valid_q, channel_qualified_q});
			end
		end
		i_host.stall = 0;
		i_host.strb = 4'h2;
		wr(tcr_pkg::ADDR_SEEK_BAND, 16'h0000);
		rd_chk(tcr_pkg::ADDR_SEEK_BAND, {8'h00, sb[7:0]});
		i_host.strb = 4'hf;
		$display("test configuration done");
		foreach (modes[i])
		begin
			wr(tcr_pkg::ADDR_PIN_CFG, {12'h000, modes[i], modes[i]});
			repeat (2) @(posedge aclk);
			check("pins", {28'h0, modes[i] != 2'h0, modes[i][1], modes[i][0], modes[i] == 2'h3},
				{28'h0, pin_oe_q, pin_out_q});
		end
		$display("test pin modes done");
		st = {14'h0, sb[5:4] == 2'h3, sb[7:6] == 2'h3};
		wr(tcr_pkg::ADDR_CONTROL, 16'hffff);
		rd_chk(tcr_pkg::ADDR_CONTROL, 16'h8100);
		check("requests", 32'h3, {30'h0, tune_request_q, seek_request_q});
		wr(tcr_pkg::ADDR_PIN_CFG, 16'h4004);
		seek_tune_finished <= 1'b1;
		@(posedge aclk);
		seek_tune_finished <= 1'b0;
		repeat (3) @(posedge aclk);
		pin_is(1'b0);
		rd_chk(tcr_pkg::ADDR_STATUS, 16'h4000 | st);
		repeat (IRQ_PULSE_CYCLES) @(posedge aclk);
		pin_is(1'b1);
		wr(tcr_pkg::ADDR_CONTROL, 16'h0000);
		check("requests", 32'h0, {30'h0, tune_request_q, seek_request_q});
		rd_chk(tcr_pkg::ADDR_STATUS, st);
		wr(tcr_pkg::ADDR_PIN_CFG, 16'h8004);
		data_group_available <= 1'b1;
		repeat (3) @(posedge aclk);
		pin_is(1'b0);
		rd_chk(tcr_pkg::ADDR_STATUS, 16'h8000 | st);
		repeat (IRQ_PULSE_CYCLES) @(posedge aclk);
		pin_is(1'b1);
		data_group_available <= 1'b0;
		wr(tcr_pkg::ADDR_PIN_CFG, 16'h0004);
		rd_chk(tcr_pkg::ADDR_STATUS, st);
		data_group_available <= 1'b1;
		repeat (3) @(posedge aclk);
		pin_is(1'b1);
		$display("test interrupt pin done");
		close_out();
	end
endmodule // tuner_config_registers_tb

bind tcr_regs tcr_regs_props #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) i_props (.*);

`default_nettype wire
